// [common/vfrps_pkg.sv]
/*
 * Constants, state type and timing figures shared by the reset pulse
 * sequencer. Assumes a 100 MHz system clock that samples the external
 * converter clock as an ordinary input.
 */
// Overview of operation
// - The frequency output is an active-low pulse of fixed width and only its repetition rate follows the input.
// - Each falling edge of the output pulse is tied to a rising edge of the external clock.
// - A comparator trip arms the sequencer.
// - An armed sequencer waits for a falling and then a rising external clock edge before a reset period.
// - From that rising edge the reset-current switch stays closed for one whole external clock cycle.
// - The reset period runs from one rising external clock edge to the next.
// - The output pulse is asserted in the same reset period as the closed switch.
// - Between the trip and the reset period nothing resets the integrator.
// - At full scale the pulses come once every two external clock periods.
// - No input can push the pulse rate above half the external clock rate.
// - Without shortening a pulse lasts one clock period, and a shortened one never more.
`default_nettype none
package vfrps_pkg;
   // ********************************************************
   // Timing
   // ********************************************************
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SHORT_PULSE_NS  = 1000;
   localparam int SHORT_PULSE_CYC =
      (SHORT_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
      SHORT_PULSE_NS / CLK_PERIOD_NS;
   localparam int SHORT_CNT_W     = 8;
   localparam logic [SHORT_CNT_W-1:0] SHORT_LAST =
      SHORT_CNT_W'(SHORT_PULSE_CYC - 1);
   localparam logic [SHORT_CNT_W-1:0] SHORT_ONE  = 8'h01;
   localparam logic [SHORT_CNT_W-1:0] SHORT_ZERO = 8'h00;

   // ********************************************************
   // Synchroniser
   // ********************************************************
   localparam int SYNC_W     = 3;
   localparam int SYNC_EXT   = 0;
   localparam int SYNC_TRIP  = 1;
   localparam int SYNC_SHORT = 2;

   // ********************************************************
   // Sequencer states
   // ********************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_FALL,
      ST_WAIT_RISE,
      ST_RESET
   } vfrps_state_e;
endpackage : vfrps_pkg
`default_nettype wire

// [common/vfrps_sync_if.sv]
/*
 * Synchronised copies of the outside inputs, passed from the input
 * synchroniser to the sequencer core. Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface vfrps_sync_if;
   logic ext_clk;
   logic trip;
   logic short_en;
   modport sync (output ext_clk, output trip, output short_en);
   modport core (input ext_clk, input trip, input short_en);
endinterface : vfrps_sync_if
`default_nettype wire

// [verilog/vfrps_sync.sv]
/*
 * Two-flop synchroniser for the pins that reach the sequencer.
 * Assumes the pins change without regard to I_CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module vfrps_sync (
   // Clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_arst_n,
   // Raw pins
   input  wire logic [vfrps_pkg::SYNC_W-1:0] i_raw,
   // Synchronised outputs
   vfrps_sync_if.sync                       sync_out
);
   import vfrps_pkg::*;

   logic [SYNC_W-1:0] meta;
   logic [SYNC_W-1:0] stable;

   // The first stage is read by the second stage only.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta   <= '0;
         stable <= '0;
      end else begin
         meta   <= i_raw;
         stable <= meta;
      end
   end

   assign sync_out.ext_clk  = stable[SYNC_EXT];
   assign sync_out.trip     = stable[SYNC_TRIP];
   assign sync_out.short_en = stable[SYNC_SHORT];
endmodule : vfrps_sync
`default_nettype wire

// [verilog/vfrps_top.sv]
/*
 * Clocked sequencing logic of a charge-balance voltage-to-frequency
 * converter: waits for the comparator trip, then for a falling and a
 * rising edge of the external clock, closes the reset-current switch
 * for one external period and drives the active-low frequency output.
 * Assumes the external clock is well below 25 MHz so that the 100 MHz
 * system clock sees each of its levels for at least two cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module vfrps_top (
   // System clock and reset
   input  wire logic  I_CLK,
   input  wire logic  I_ARST_N,
   // External converter clock, comparator and one-shot control pins
   input  wire logic  I_EXT_CLK,
   input  wire logic  I_COMP_TRIP,
   input  wire logic  I_SHORT_EN,
   // Reset-current switch drive
   output var  logic  O_RESET_CURRENT_SWITCH,
   // Open-collector frequency output
   output var  logic  O_PULSE_OUTPUT_FREQUENCY_N,
   output var  logic  O_PULSE_OUTPUT_FREQUENCY_OE
);
   import vfrps_pkg::*;

   // ********************************************************
   // Input synchronisation
   // ********************************************************
   vfrps_sync_if sync_bus ();

   vfrps_sync u_sync (
      .i_clk    (I_CLK),
      .i_arst_n (I_ARST_N),
      .i_raw    ({I_SHORT_EN, I_COMP_TRIP, I_EXT_CLK}),
      .sync_out (sync_bus.sync)
   );

   // ********************************************************
   // External clock edge detection
   // ********************************************************
   logic ext_prev;
   logic ext_rise;
   logic ext_fall;

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= sync_bus.ext_clk;
      end
   end

   assign ext_rise = sync_bus.ext_clk & ~ext_prev;
   assign ext_fall = ~sync_bus.ext_clk & ext_prev;

   // ********************************************************
   // Sequencer
   // ********************************************************
   vfrps_state_e state;
   vfrps_state_e next_state;

   // The trip is a level: a sequencer that has just left the reset
   // period rearms at once if the integrator is still past threshold,
   // which yields the half-rate ceiling at and above full scale.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (sync_bus.trip) begin
               next_state = ST_WAIT_FALL;
            end
         end
         ST_WAIT_FALL: begin
            if (ext_fall) begin
               next_state = ST_WAIT_RISE;
            end
         end
         ST_WAIT_RISE: begin
            if (ext_rise) begin
               next_state = ST_RESET;
            end
         end
         ST_RESET: begin
            if (ext_rise) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ********************************************************
   // Reset-current switch
   // ********************************************************
   logic switch_closed;

   // Integration goes on untouched until the switch closes.
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         switch_closed <= 1'b0;
      end else begin
         switch_closed <= (next_state == ST_RESET);
      end
   end

   assign O_RESET_CURRENT_SWITCH = switch_closed;

   // ********************************************************
   // Output pulse and one-shot
   // ********************************************************
   logic                   pulse_on;
   logic                   pulse_n;
   logic [SHORT_CNT_W-1:0] pulse_cnt;
   logic                   start_reset;
   logic                   short_done;

   assign start_reset = (state == ST_WAIT_RISE) && ext_rise;
   assign short_done  = sync_bus.short_en && (pulse_cnt == SHORT_LAST);

   // The one-shot can only cut the pulse short; the end of the reset
   // period always ends it, so it never outlasts one clock period.
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pulse_on <= 1'b0;
         pulse_n  <= 1'b1;
      end else if (start_reset) begin
         pulse_on <= 1'b1;
         pulse_n  <= 1'b0;
      end else if (next_state != ST_RESET || short_done) begin
         pulse_on <= 1'b0;
         pulse_n  <= 1'b1;
      end
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         pulse_cnt <= SHORT_ZERO;
      end else if (start_reset) begin
         pulse_cnt <= SHORT_ZERO;
      end else if (pulse_on && pulse_cnt != SHORT_LAST) begin
         pulse_cnt <= pulse_cnt + SHORT_ONE;
      end
   end

   assign O_PULSE_OUTPUT_FREQUENCY_N  = pulse_n;
   assign O_PULSE_OUTPUT_FREQUENCY_OE = pulse_on;

   // ********************************************************
   // Checks
   // ********************************************************
   logic fall_since_reset;

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         fall_since_reset <= 1'b1;
      end else if (switch_closed) begin
         fall_since_reset <= 1'b0;
      end else if (ext_fall) begin
         fall_since_reset <= 1'b1;
      end
   end

   sequence s_armed_edge;
      (state == ST_WAIT_RISE) && ext_rise;
   endsequence

   sequence s_switch_and_pulse;
      switch_closed && pulse_on;
   endsequence

   property p_trip_arms;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      (state == ST_IDLE) && sync_bus.trip |=> (state == ST_WAIT_FALL);
   endproperty
   a_trip_arms: assert property (p_trip_arms)
      else $error("Trip did not arm the sequencer.");

   property p_fall_before_rise;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      $rose(switch_closed) |-> $past(state) == ST_WAIT_RISE;
   endproperty
   a_fall_before_rise: assert property (p_fall_before_rise)
      else $error("Switch closed without a falling then rising edge.");

   property p_start_on_rise;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      s_armed_edge |=> s_switch_and_pulse;
   endproperty
   a_start_on_rise: assert property (p_start_on_rise)
      else $error("Reset period did not start on the rising edge.");

   property p_hold_switch;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      switch_closed && !ext_rise |=> switch_closed;
   endproperty
   a_hold_switch: assert property (p_hold_switch)
      else $error("Switch opened before the next rising edge.");

   property p_end_on_rise;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      switch_closed && ext_rise |=> !switch_closed && !pulse_on;
   endproperty
   a_end_on_rise: assert property (p_end_on_rise)
      else $error("Reset period outlasted one clock period.");

   property p_pulse_within;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      pulse_on |-> switch_closed;
   endproperty
   a_pulse_within: assert property (p_pulse_within)
      else $error("Output pulse outside the reset period.");

   property p_full_pulse;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      switch_closed && !sync_bus.short_en |-> pulse_on;
   endproperty
   a_full_pulse: assert property (p_full_pulse)
      else $error("Unshortened pulse shorter than the reset period.");

   property p_short_width;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      pulse_on && sync_bus.short_en && (pulse_cnt == SHORT_LAST)
      |=> !pulse_on;
   endproperty
   a_short_width: assert property (p_short_width)
      else $error("Shortened pulse exceeded its width.");

   property p_rate_limit;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      $rose(switch_closed) |-> fall_since_reset;
   endproperty
   a_rate_limit: assert property (p_rate_limit)
      else $error("Reset periods closer than two clock periods.");

   property p_no_early_reset;
      @(posedge I_CLK) disable iff (!I_ARST_N)
      (state == ST_WAIT_FALL) |-> !switch_closed;
   endproperty
   a_no_early_reset: assert property (p_no_early_reset)
      else $error("Integrator reset while awaiting clock edges.");
endmodule : vfrps_top
`default_nettype wire

// [bench/vfrps_counter_model.sv]
/*
 * Far-side model: logic that counts the pulses on the open-collector
 * frequency output. Assumes a pull-up on the line and the bench clock.
 */
`timescale 1ns/1ps
`default_nettype none
module vfrps_counter_model (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   // Sink enable of the open-collector output
   input  wire logic        i_pull_low,
   // Number of falling edges seen on the line
   output var  logic [15:0] o_count
);
   wire  logic line;
   logic       line_d;

   // The pull-up brings the line high whenever nobody sinks it.
   assign line = i_pull_low ? 1'b0 : 1'b1;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         line_d  <= 1'b1;
         o_count <= 16'h0000;
      end else begin
         line_d <= line;
         if (line_d && !line) begin
            o_count <= o_count + 16'h0001;
         end
      end
   end
endmodule : vfrps_counter_model
`default_nettype wire

// [bench/vfrps_top_test.sv]
/*
 * Self-checking bench of the reset pulse sequencer with a pulse counter.
 * Assumes the external clock halves last at least four system cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module vfrps_top_test;
   import vfrps_pkg::*;
   logic I_CLK, I_ARST_N, I_EXT_CLK, I_COMP_TRIP, I_SHORT_EN;
   logic sw, pn, oe, sw_d, oe_d, sat;
   logic [15:0] rx_count, lfsr;
   int errors, tests_run, cyc, rise_cyc, prev_rise, fall_cyc, fall_pre;
   int trip_cyc, oe_start, last_start, sw_pulses;
   int half = 4;

   vfrps_top dut_u (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
      .I_EXT_CLK(I_EXT_CLK), .I_COMP_TRIP(I_COMP_TRIP),
      .I_SHORT_EN(I_SHORT_EN), .O_RESET_CURRENT_SWITCH(sw),
      .O_PULSE_OUTPUT_FREQUENCY_N(pn), .O_PULSE_OUTPUT_FREQUENCY_OE(oe));
   vfrps_counter_model far_u (.i_clk(I_CLK), .i_arst_n(I_ARST_N),
      .i_pull_low(oe), .o_count(rx_count));

   // ********************************************************
   // Helpers
   // ********************************************************
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
      end
   endtask : check

   function automatic logic [15:0] step(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : step

   // A one-shot longer than the period has no effect on the width.
   function automatic int exp_width(int period, logic short_on);
      return (short_on && period > SHORT_PULSE_CYC) ? SHORT_PULSE_CYC :
             period;
   endfunction : exp_width

   task automatic wait_sw(logic v);
      int n;
      n = 0;
      while (sw !== v && n < 1000) begin
         @(negedge I_CLK);
         n++;
      end
      check("wait limit", n < 1000, 1'b1);
      @(posedge I_CLK);
   endtask : wait_sw

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   // ********************************************************
   // Clocks
   // ********************************************************
   initial begin
      I_CLK = 1'b0;
      forever #5 I_CLK = ~I_CLK;
   end

   always @(posedge I_CLK) cyc++;

   // A new half period only takes effect at the next toggle.
   initial begin
      I_EXT_CLK = 1'b0;
      forever begin
         repeat (half) @(posedge I_CLK);
         #1 I_EXT_CLK = ~I_EXT_CLK;
         if (I_EXT_CLK) begin
            prev_rise = rise_cyc;
            rise_cyc = cyc;
            fall_pre = fall_cyc;
         end else begin
            fall_cyc = cyc;
         end
      end
   end

   // ********************************************************
   // Output monitor
   // ********************************************************
   always @(negedge I_CLK) begin
      if (I_ARST_N) begin
         check("pulse level", pn, !oe);
         if (sw && !sw_d) begin
            check("switch start lag", cyc - rise_cyc, 3);
            check("pulse with switch", oe, 1'b1);
            if (!sat) begin
               check("fall after trip", fall_pre > trip_cyc, 1'b1);
            end
            if (sat && last_start > 0) begin
               check("full rate", cyc - last_start,
                     2 * (rise_cyc - prev_rise));
            end
            last_start = cyc;
            sw_pulses++;
         end
         if (!sw && sw_d) begin
            check("switch end lag", cyc - rise_cyc, 3);
            check("switch width", cyc - last_start,
                  rise_cyc - prev_rise);
         end
         if (oe && !oe_d) begin
            oe_start = cyc;
         end
         if (!oe && oe_d) begin
            check("pulse width", cyc - oe_start,
                  exp_width(rise_cyc - prev_rise, I_SHORT_EN));
         end
      end
      sw_d = sw;
      oe_d = oe;
   end

   initial begin
      #500us;
      errors++;
      stop_test();
   end

   // ********************************************************
   // Scenarios
   // ********************************************************
   initial begin
      I_ARST_N = 1'b0;
      I_COMP_TRIP = 1'b0;
      I_SHORT_EN = 1'b0;
      lfsr = 16'h3135;
      sat = 1'b1;
      repeat (5) @(posedge I_CLK);
      #1 I_ARST_N = 1'b1;
      // Trip held high is the overrange case: rate must saturate.
      I_COMP_TRIP = 1'b1;
      repeat (300) @(posedge I_CLK);
      #1 I_COMP_TRIP = 1'b0;
      repeat (40) @(posedge I_CLK);
      sat = 1'b0;
      for (int i = 0; i < 24; i++) begin
         lfsr = step(lfsr);
         half = (i < 2) ? 40 + 20 * i : 4 + int'(lfsr[2:0]);
         #1 I_SHORT_EN = (i < 2) ? 1'b1 : lfsr[3];
         repeat (300 + int'(lfsr[7:4])) @(posedge I_CLK);
         #1 I_COMP_TRIP = 1'b1;
         trip_cyc = cyc;
         wait_sw(1'b1);
         #1 I_COMP_TRIP = 1'b0;
         wait_sw(1'b0);
      end
      repeat (10) @(posedge I_CLK);
      check("counted pulses", rx_count, sw_pulses);
      stop_test();
   end
endmodule : vfrps_top_test
`default_nettype wire
